// ===== src/mgc_measure_control.sv
// measurement sequencing, self-test drive, restart and continuous mode of the magnetometer
// Overview of operation
// - bandwidth code 00/01/10/11 sets measurement time 6.6/3.5/2.0/1.2 ms
// - X, Y, Z converted in turn, one third of measurement time apart
// - a channel with its skip bit set is left out of the sequence
// - skipped channel gets no conversion strobe, so its result stays unchanged
// - positive self-test bit drives DC current through the self-test coil
// - negative self-test bit drives the coil with opposite field polarity
// - soft restart clears all registers and reloads trim, as at power-up
// - restart lasts 20 ms; host waits before normal operation
// - interval code 000..111 gives one set per 1..2000 samples
// - periodic set only with its enable, auto magnetize and continuous mode
// - during periodic set operation no reset pulses are issued
// - continuous mode entered only with non-zero rate and period calculated first
// - period counter starts from zero when continuous mode is enabled
// - high-rate bit allows continuous output rate up to 1000 Hz
// - two factory interrupt enables reset to zero and stay zero
// - skipping a channel shortens measurement time and charge used
// - period calculation trigger computes period and then clears itself
// - 1000 Hz only with rate byte 255 and high-rate bit set
// - auto magnetize puts set/reset pulses around every measurement while periodic set is not active
`include "mgc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mgc_measure_control
    import mgc_pkg::*;
#(
    parameter int SLOT_BW0_CYC = `MGC_MEAS_BW0_NS / `MGC_CLK_NS / `MGC_AXIS_COUNT,
    parameter int SLOT_BW1_CYC = `MGC_MEAS_BW1_NS / `MGC_CLK_NS / `MGC_AXIS_COUNT,
    parameter int SLOT_BW2_CYC = `MGC_MEAS_BW2_NS / `MGC_CLK_NS / `MGC_AXIS_COUNT,
    parameter int SLOT_BW3_CYC = `MGC_MEAS_BW3_NS / `MGC_CLK_NS / `MGC_AXIS_COUNT,
    parameter int RESTART_CYC = `MGC_RESTART_NS / `MGC_CLK_NS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register writes
    input wire mgc_wr_s wr,
    // control bits held outside this block
    input wire logic meas_req,
    input wire logic auto_magnetize_en,
    input wire logic period_calc_req,
    input wire logic [7:0] output_rate,
    // sensor element drive
    output mgc_drv_s drv
);
    localparam int PULSE_CYC = (`MGC_MAG_PULSE_NS + `MGC_CLK_NS - 1) / `MGC_CLK_NS;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_int_n;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_int_n = rst_sync_reg[1];

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] slot_cyc(input logic [1:0] bw);
        unique case (bw)
            2'h0: slot_cyc = 32'(SLOT_BW0_CYC - 1);
            2'h1: slot_cyc = 32'(SLOT_BW1_CYC - 1);
            2'h2: slot_cyc = 32'(SLOT_BW2_CYC - 1);
            2'h3: slot_cyc = 32'(SLOT_BW3_CYC - 1);
        endcase
    endfunction : slot_cyc

    function automatic logic [10:0] prd_samples(input logic [2:0] code);
        unique case (code)
            3'h0: prd_samples = 11'h001;
            3'h1: prd_samples = 11'h019;
            3'h2: prd_samples = 11'h04B;
            3'h3: prd_samples = 11'h064;
            3'h4: prd_samples = 11'h0FA;
            3'h5: prd_samples = 11'h1F4;
            3'h6: prd_samples = 11'h3E8;
            3'h7: prd_samples = 11'h7D0;
        endcase
    endfunction : prd_samples

    // first enabled axis at or after start, 3 when none remain
    function automatic logic [1:0] next_axis(input logic [2:0] skip, input logic [1:0] start);
        next_axis = 2'h3;
        for (int i = 2; i >= 0; i--)
        begin
            if (!skip[i] && 2'(i) >= start)
                next_axis = 2'(i);
        end
    endfunction : next_axis

    // ----------------------------------------
    // state
    // ----------------------------------------
    mgc_state_s s_reg;
    mgc_state_s s_next;
    logic prd_active;
    logic tick;
    logic [26:0] acc_sum;
    logic [1:0] first_ax;
    logic [1:0] follow_ax;

    assign prd_active = s_reg.ctl2[`MGC_C2_PRD_EN] && auto_magnetize_en && s_reg.cmm;
    assign acc_sum = {1'b0, s_reg.acc} + {16'h0, s_reg.step};
    assign tick = s_reg.cmm && (acc_sum >= {1'b0, `MGC_CLK_HZ});
    assign first_ax = next_axis(s_reg.ctl1[`MGC_C1_SKIP_LO +: 3], `MGC_AXIS_X);
    assign follow_ax = next_axis(s_reg.skip, s_reg.drv.conv_axis + 2'h1);

    always_comb
    begin
        s_next = s_reg;
        s_next.drv.conv_start = 1'b0;
        s_next.drv.meas_done = 1'b0;
        s_next.drv.trim_reload = 1'b0;
        // continuous-mode period accumulator
        if (s_reg.cmm)
            s_next.acc = tick ? 26'(acc_sum - {1'b0, `MGC_CLK_HZ}) : acc_sum[25:0];
        // period calculation, done in one cycle
        if (s_reg.drv.calc_busy)
        begin
            if (s_reg.ctl2[`MGC_C2_HIGH_RATE] && output_rate == `MGC_RATE_FULL)
                s_next.step = `MGC_HIGH_RATE_HZ;
            else
                s_next.step = {3'h0, output_rate};
            s_next.calc_ok = 1'b1;
            s_next.drv.calc_busy = 1'b0;
        end
        // measurement sequencer
        unique case (s_reg.st)
            MGC_IDLE:
            begin
                if ((meas_req || tick) && s_reg.rcnt == 32'h0)
                begin
                    s_next.skip = s_reg.ctl1[`MGC_C1_SKIP_LO +: 3];
                    s_next.drv.meas_busy = 1'b1;
                    s_next.prd_now = prd_active;
                    if (prd_active)
                        s_next.smp = (s_reg.smp == 11'h0) ? prd_samples(s_reg.ctl2[2:0]) - 11'h1 : s_reg.smp - 11'h1;
                    if ((auto_magnetize_en && !prd_active) || (prd_active && s_reg.smp == 11'h0))
                    begin
                        s_next.st = MGC_SETP;
                        s_next.drv.set_pulse = 1'b1;
                        s_next.tmr = 32'(PULSE_CYC - 1);
                    end
                    else
                    begin
                        s_next.st = MGC_CONV;
                        s_next.drv.conv_axis = first_ax;
                        s_next.drv.conv_start = (first_ax != 2'h3);
                        s_next.tmr = slot_cyc(s_reg.ctl1[1:0]);
                    end
                end
            end
            MGC_SETP:
            begin
                s_next.tmr = s_reg.tmr - 32'h1;
                if (s_reg.tmr == 32'h0)
                begin
                    s_next.drv.set_pulse = 1'b0;
                    s_next.st = MGC_CONV;
                    s_next.drv.conv_axis = next_axis(s_reg.skip, `MGC_AXIS_X);
                    s_next.drv.conv_start = (next_axis(s_reg.skip, `MGC_AXIS_X) != 2'h3);
                    s_next.tmr = slot_cyc(s_reg.ctl1[1:0]);
                end
            end
            MGC_CONV:
            begin
                s_next.tmr = s_reg.tmr - 32'h1;
                if (s_reg.tmr == 32'h0 || s_reg.drv.conv_axis == 2'h3)
                begin
                    if (s_reg.drv.conv_axis != 2'h3 && follow_ax != 2'h3)
                    begin
                        s_next.drv.conv_axis = follow_ax;
                        s_next.drv.conv_start = 1'b1;
                        s_next.tmr = slot_cyc(s_reg.ctl1[1:0]);
                    end
                    else if (auto_magnetize_en && !s_reg.prd_now)
                    begin
                        s_next.st = MGC_RSTP;
                        s_next.drv.reset_pulse = 1'b1;
                        s_next.tmr = 32'(PULSE_CYC - 1);
                    end
                    else
                    begin
                        s_next.st = MGC_IDLE;
                        s_next.drv.meas_busy = 1'b0;
                        s_next.drv.meas_done = 1'b1;
                    end
                end
            end
            MGC_RSTP:
            begin
                s_next.tmr = s_reg.tmr - 32'h1;
                if (s_reg.tmr == 32'h0)
                begin
                    s_next.st = MGC_IDLE;
                    s_next.drv.reset_pulse = 1'b0;
                    s_next.drv.meas_busy = 1'b0;
                    s_next.drv.meas_done = 1'b1;
                end
            end
            default:
                s_next.st = MGC_IDLE;
        endcase
        // restart interval, writes refused meanwhile
        if (s_reg.rcnt != 32'h0)
        begin
            s_next.rcnt = s_reg.rcnt - 32'h1;
            s_next.drv.restart_busy = (s_reg.rcnt != 32'h1);
        end
        else if (period_calc_req)
            s_next.drv.calc_busy = 1'b1;
        // register writes
        if (wr.en && s_reg.rcnt == 32'h0)
        begin
            unique case (wr.addr)
                `MGC_ADDR_CTL1:
                begin
                    s_next.ctl1 = wr.data;
                    if (wr.data[`MGC_C1_RESTART])
                    begin
                        s_next = '0;
                        s_next.rcnt = 32'(RESTART_CYC);
                        s_next.drv.restart_busy = 1'b1;
                        s_next.drv.trim_reload = 1'b1;
                    end
                end
                `MGC_ADDR_CTL2:
                begin
                    s_next.ctl2 = wr.data;
                    s_next.ctl2[`MGC_C2_FACTORY_HI] = 1'b0;
                    s_next.ctl2[`MGC_C2_FACTORY_LO] = 1'b0;
                    s_next.cmm = wr.data[`MGC_C2_CMM] && output_rate != 8'h0 && s_reg.calc_ok;
                    s_next.ctl2[`MGC_C2_CMM] = s_next.cmm;
                    if (s_next.cmm && !s_reg.cmm)
                    begin
                        s_next.acc = 26'h0;
                        s_next.smp = 11'h0;
                    end
                end
                `MGC_ADDR_XLIM: s_next.drv.x_selftest_limit = wr.data;
                `MGC_ADDR_YLIM: s_next.drv.y_selftest_limit = wr.data;
                default: s_next.drv.calc_busy = s_next.drv.calc_busy;
            endcase
        end
        s_next.drv.selftest_pos_drive = s_next.ctl1[`MGC_C1_ST_POS];
        s_next.drv.selftest_neg_drive = s_next.ctl1[`MGC_C1_ST_NEG];
        s_next.ctl1[`MGC_C1_RESTART] = 1'b0;
        s_next.drv.bandwidth_sel = s_next.ctl1[1:0];
        s_next.drv.cmm_active = s_next.cmm;
    end

    always_ff @(posedge clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign drv = s_reg.drv;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_calc_self_clear: assert property (@(posedge clk) disable iff (!rst_int_n)
        drv.calc_busy && s_reg.rcnt == 32'h0 |=> !drv.calc_busy && s_reg.calc_ok)
        else $error("period calculation trigger did not clear");
    a_cmm_entry_gate: assert property (@(posedge clk) disable iff (!rst_int_n)
        $rose(s_reg.cmm) |-> $past(s_reg.calc_ok) && $past(output_rate) != 8'h0)
        else $error("continuous mode entered without rate or calculation");
    a_cmm_acc_start: assert property (@(posedge clk) disable iff (!rst_int_n)
        $rose(s_reg.cmm) |-> s_reg.acc == 26'h0)
        else $error("period counter did not start from zero");
    a_skip_no_conv: assert property (@(posedge clk) disable iff (!rst_int_n)
        drv.conv_start |-> drv.conv_axis != 2'h3 && !s_reg.skip[drv.conv_axis])
        else $error("skipped channel was converted");
    a_conv_gap_hold: assert property (@(posedge clk) disable iff (!rst_int_n)
        drv.conv_start |=> (!drv.conv_start)[*8])
        else $error("channel conversions too close together");
    a_periodic_no_reset: assert property (@(posedge clk) disable iff (!rst_int_n)
        s_reg.prd_now && drv.meas_busy |-> !drv.reset_pulse)
        else $error("reset pulse during periodic set");
    a_factory_bits_zero: assert property (@(posedge clk) disable iff (!rst_int_n)
        s_reg.ctl2[`MGC_C2_FACTORY_HI:`MGC_C2_FACTORY_LO] == 2'h0)
        else $error("factory enables not zero");
    a_restart_clears: assert property (@(posedge clk) disable iff (!rst_int_n)
        $rose(drv.trim_reload) |-> s_reg.ctl1 == 8'h0 && s_reg.ctl2 == 8'h0 && drv.restart_busy)
        else $error("restart did not clear registers");
    a_set_pulse_len: assert property (@(posedge clk) disable iff (!rst_int_n)
        $rose(drv.set_pulse) |-> drv.set_pulse[*8])
        else $error("set pulse too short");
    a_selftest_drive: assert property (@(posedge clk) disable iff (!rst_int_n)
        drv.selftest_pos_drive == s_reg.ctl1[`MGC_C1_ST_POS] && drv.selftest_neg_drive == s_reg.ctl1[`MGC_C1_ST_NEG])
        else $error("self-test coil drive does not follow register");
endmodule : mgc_measure_control
`default_nettype wire

// ===== src/mgc_params.svh
// constants of the magnetometer measurement control block
`ifndef MGC_PARAMS_SVH
`define MGC_PARAMS_SVH
`define MGC_CLK_NS 25
`define MGC_CLK_HZ 26'h2625A00
`define MGC_HIGH_RATE_HZ 11'h3E8
`define MGC_RATE_FULL 8'hFF
`define MGC_MEAS_BW0_NS 6600000
`define MGC_MEAS_BW1_NS 3500000
`define MGC_MEAS_BW2_NS 2000000
`define MGC_MEAS_BW3_NS 1200000
`define MGC_AXIS_COUNT 3
`define MGC_RESTART_NS 20000000
`define MGC_MAG_PULSE_NS 375
`define MGC_ADDR_CTL1 8'h1C
`define MGC_ADDR_CTL2 8'h1D
`define MGC_ADDR_XLIM 8'h1E
`define MGC_ADDR_YLIM 8'h1F
`define MGC_C1_RESTART 7
`define MGC_C1_ST_NEG 6
`define MGC_C1_ST_POS 5
`define MGC_C1_SKIP_LO 2
`define MGC_C2_HIGH_RATE 7
`define MGC_C2_FACTORY_HI 6
`define MGC_C2_FACTORY_LO 5
`define MGC_C2_CMM 4
`define MGC_C2_PRD_EN 3
`define MGC_AXIS_X 2'h0
`define MGC_AXIS_Y 2'h1
`define MGC_AXIS_Z 2'h2
`define MGC_RESET_BYTE 8'h00
`endif

// ===== src/mgc_pkg.sv
// types of the magnetometer measurement control block
package mgc_pkg;
    typedef enum logic [2:0] {
        MGC_IDLE = 3'b000,
        MGC_SETP = 3'b001,
        MGC_CONV = 3'b010,
        MGC_RSTP = 3'b011
    } mgc_state_e;
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } mgc_wr_s;
    typedef struct packed {
        logic conv_start;
        logic [1:0] conv_axis;
        logic meas_busy;
        logic meas_done;
        logic set_pulse;
        logic reset_pulse;
        logic selftest_pos_drive;
        logic selftest_neg_drive;
        logic [1:0] bandwidth_sel;
        logic [7:0] x_selftest_limit;
        logic [7:0] y_selftest_limit;
        logic trim_reload;
        logic restart_busy;
        logic cmm_active;
        logic calc_busy;
    } mgc_drv_s;
    typedef struct packed {
        mgc_state_e st;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [2:0] skip;
        logic [31:0] tmr;
        logic [25:0] acc;
        logic [10:0] step;
        logic calc_ok;
        logic cmm;
        logic prd_now;
        logic [10:0] smp;
        logic [31:0] rcnt;
        mgc_drv_s drv;
    } mgc_state_s;
endpackage : mgc_pkg

// ===== bench/mgc_sensor_model.sv
// behavioural model of the sensing bridges, self-test coil and result registers
`timescale 1ns/1ps
`default_nettype none
module mgc_sensor_model
    import mgc_pkg::*;
#(
    parameter logic [19:0] FIELD_BASE = 20'h80000,
    parameter logic [19:0] ST_OFS = 20'h01000
)
(
    // clock
    input wire logic clk,
    // drive from the block
    input wire mgc_drv_s drv,
    // conversion results
    output logic [19:0] x_res,
    output logic [19:0] y_res,
    output logic [19:0] z_res
);
    logic [19:0] field;
    // ------------------------------------------------------------
    // sensed field with self-test offset
    // ------------------------------------------------------------
    always_comb
    begin
        field = FIELD_BASE;
        if (drv.selftest_pos_drive)
            field = field + ST_OFS;
        if (drv.selftest_neg_drive)
            field = field - ST_OFS;
    end
    // ------------------------------------------------------------
    // only the strobed axis takes a new result
    // ------------------------------------------------------------
    initial
    begin
        x_res = 20'h00000;
        y_res = 20'h00000;
        z_res = 20'h00000;
    end
    always @(posedge clk)
    begin
        if (drv.conv_start && drv.conv_axis == 2'h0)
            x_res <= field;
        if (drv.conv_start && drv.conv_axis == 2'h1)
            y_res <= field + 20'h00001;
        if (drv.conv_start && drv.conv_axis == 2'h2)
            z_res <= field + 20'h00002;
    end
endmodule : mgc_sensor_model
`default_nettype wire

// ===== bench/test_magnetometer_measure_control.sv
// self-checking testbench of the measurement control block
`include "mgc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_magnetometer_measure_control;
    import mgc_pkg::*;
    localparam int SLOT [4] = '{24, 15, 12, 9};
    localparam int RST_CYC = 50;
    localparam int PULSE_CYC = `MGC_MAG_PULSE_NS / `MGC_CLK_NS;
    localparam logic [19:0] BASE = 20'h80000;
    localparam logic [19:0] OFS = 20'h01000;
    logic clk;
    logic rst_n = 1'b0;
    mgc_wr_s wr = '0;
    logic meas_req = 1'b0;
    logic auto_magnetize_en = 1'b0;
    logic period_calc_req = 1'b0;
    logic [7:0] output_rate = 8'h00;
    mgc_drv_s drv;
    logic [19:0] x_res, y_res, z_res;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n_conv, t_done, set_cnt, rsp_cnt, set_last, rsp_first;
    logic [1:0] ax [3];
    int tc [3];
    mgc_measure_control #(.SLOT_BW0_CYC(24), .SLOT_BW1_CYC(15), .SLOT_BW2_CYC(12), .SLOT_BW3_CYC(9),
        .RESTART_CYC(RST_CYC)) dut_u (.clk(clk), .rst_n(rst_n), .wr(wr), .meas_req(meas_req),
        .auto_magnetize_en(auto_magnetize_en), .period_calc_req(period_calc_req),
        .output_rate(output_rate), .drv(drv));
    mgc_sensor_model #(.FIELD_BASE(BASE), .ST_OFS(OFS)) model_u (.clk(clk), .drv(drv),
        .x_res(x_res), .y_res(y_res), .z_res(z_res));
    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= '{en: 1'b1, addr: a, data: d};
        @(posedge clk);
        wr.en <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic measure();
        n_conv = 0;
        set_cnt = 0;
        rsp_cnt = 0;
        set_last = -1;
        rsp_first = -1;
        t_done = -1;
        @(posedge clk);
        meas_req <= 1'b1;
        @(posedge clk);
        meas_req <= 1'b0;
        repeat (600)
        begin
            #1;
            if (drv.conv_start && n_conv < 3)
            begin
                ax[n_conv] = drv.conv_axis;
                tc[n_conv] = cyc;
                n_conv++;
            end
            if (drv.set_pulse)
            begin
                set_cnt++;
                set_last = cyc;
            end
            if (drv.reset_pulse && rsp_first < 0)
                rsp_first = cyc;
            if (drv.reset_pulse)
                rsp_cnt++;
            if (drv.meas_done)
                t_done = cyc;
            if (drv.meas_done)
                break;
            @(posedge clk);
        end
        chk("done seen", t_done >= 0, 1);
    endtask : measure
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        wr_reg(`MGC_ADDR_XLIM, 8'h5A);
        wr_reg(`MGC_ADDR_YLIM, 8'hA5);
        wr_reg(8'h1B, 8'h33);
        chk("x limit", drv.x_selftest_limit, 8'h5A);
        chk("y limit", drv.y_selftest_limit, 8'hA5);
        wr_reg(`MGC_ADDR_CTL1, 8'h20);
        chk("pos drive", {drv.selftest_pos_drive, drv.selftest_neg_drive}, 2'b10);
        wr_reg(`MGC_ADDR_CTL1, 8'h43);
        chk("neg drive", {drv.selftest_pos_drive, drv.selftest_neg_drive}, 2'b01);
        chk("bandwidth", drv.bandwidth_sel, 2'h3);
        $display("test regs done");
    endtask : t_regs
    task automatic t_bw();
        for (int b = 0; b < 4; b++)
        begin
            wr_reg(`MGC_ADDR_CTL1, 8'(b));
            measure();
            chk("axes", n_conv, 3);
            chk("order", {ax[0], ax[1], ax[2]}, {`MGC_AXIS_X, `MGC_AXIS_Y, `MGC_AXIS_Z});
            chk("gap xy", tc[1] - tc[0], SLOT[b]);
            chk("gap yz", tc[2] - tc[1], SLOT[b]);
            chk("length", t_done - tc[0], 3 * SLOT[b]);
        end
        $display("test bandwidth done");
    endtask : t_bw
    task automatic t_skip();
        wr_reg(`MGC_ADDR_CTL1, 8'h00);
        measure();
        wr_reg(`MGC_ADDR_CTL1, 8'h38);
        measure();
        chk("one axis", {n_conv, ax[0]}, {32'd1, `MGC_AXIS_X});
        chk("short", t_done - tc[0], SLOT[0]);
        chk("x offset", x_res, BASE + OFS);
        chk("y kept", y_res, BASE + 20'h00001);
        chk("z kept", z_res, BASE + 20'h00002);
        wr_reg(`MGC_ADDR_CTL1, 8'h44);
        measure();
        chk("y z only", {n_conv, ax[0], ax[1]}, {32'd2, `MGC_AXIS_Y, `MGC_AXIS_Z});
        chk("y neg", y_res, BASE - OFS + 20'h00001);
        chk("x kept", x_res, BASE + OFS);
        $display("test skip done");
    endtask : t_skip
    task automatic t_auto();
        auto_magnetize_en <= 1'b1;
        wr_reg(`MGC_ADDR_CTL1, 8'h03);
        measure();
        chk("set len", set_cnt, PULSE_CYC);
        chk("reset len", rsp_cnt, PULSE_CYC);
        chk("set first", set_last < tc[0], 1);
        chk("reset last", rsp_first > tc[2], 1);
        auto_magnetize_en <= 1'b0;
        $display("test magnetize done");
    endtask : t_auto
    task automatic t_restart();
        int n;
        wr_reg(`MGC_ADDR_XLIM, 8'h77);
        wr_reg(`MGC_ADDR_CTL1, 8'h20);
        wr_reg(`MGC_ADDR_CTL1, 8'h80);
        chk("trim", {drv.trim_reload, drv.restart_busy}, 2'b11);
        chk("cleared", {drv.selftest_pos_drive, drv.x_selftest_limit}, 9'h000);
        n = 1;
        wr_reg(`MGC_ADDR_XLIM, 8'h55);
        n = n + 2;
        repeat (200)
        begin
            @(posedge clk);
            #1;
            if (!drv.restart_busy)
                break;
            n++;
        end
        chk("restart len", n, RST_CYC);
        chk("write refused", drv.x_selftest_limit, 8'h00);
        $display("test restart done");
    endtask : t_restart
    task automatic t_cmm();
        output_rate <= 8'd100;
        wr_reg(`MGC_ADDR_CTL2, 8'h10);
        chk("no calc", drv.cmm_active, 1'b0);
        @(posedge clk);
        period_calc_req <= 1'b1;
        @(posedge clk);
        period_calc_req <= 1'b0;
        #1;
        chk("calc busy", drv.calc_busy, 1'b1);
        @(posedge clk);
        #1;
        chk("calc clear", drv.calc_busy, 1'b0);
        output_rate <= 8'd0;
        wr_reg(`MGC_ADDR_CTL2, 8'h10);
        chk("zero rate", drv.cmm_active, 1'b0);
        output_rate <= 8'd100;
        wr_reg(`MGC_ADDR_CTL2, 8'h10);
        chk("entered", drv.cmm_active, 1'b1);
        $display("test continuous done");
    endtask : t_cmm
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_bw();
        t_skip();
        t_auto();
        t_restart();
        t_cmm();
        report_and_stop();
    end
endmodule : test_magnetometer_measure_control
`default_nettype wire
